// ---- rtl/ept_encoder_position_tracker.sv ----
`timescale 1ns/10ps
module ept_encoder_position_tracker
  import ept_pkg::*;
#(
  parameter int PW          = ept_pkg::POS_W,
  parameter int COUNTS_REV  = 4096,
  parameter int COMM_CYC    = ept_pkg::COMM_PERIOD_CYC
) (
  input  wire logic                    clock,            // 250 MHz clock
  input  wire logic                    srst,             // Sync reset, high
  input  wire logic                    motor_chan_a,     // Motor A / sine comparator
  input  wire logic                    motor_chan_b,     // Motor B / cosine comparator
  input  wire logic                    motor_index,      // Motor index
  input  wire logic                    hall_in_1,        // Hall sensor 1
  input  wire logic                    hall_in_2,        // Hall sensor 2
  input  wire logic                    hall_in_3,        // Hall sensor 3
  input  wire logic                    aux_chan_a,       // Aux A
  input  wire logic                    aux_chan_b,       // Aux B
  input  wire logic                    aux_index,        // Aux index
  input  wire logic [1:0]              torque_disable_input, // Both high to enable
  input  wire logic                    sincos_mode,      // Motor feedback is sine/cosine
  input  wire logic                    absolute_mode,    // Absolute feedback, no index
  input  wire ept_pkg::ept_turns_t     turns_type,       // Multi-turn range select
  input  wire logic                    hall_present,     // Hall sensor fitted
  output logic signed [PW-1:0]         motor_position,   // Motor count
  output logic                         motor_marker,     // Index or synthetic marker pulse
  output logic                         motor_quad_error, // Motor quad error pulse
  output logic signed [PW-1:0]         aux_position,     // Aux count
  output logic                         aux_marker,       // Aux index pulse
  output logic                         aux_quad_error,   // Aux quad error pulse
  output logic [ept_pkg::ANGLE_W-1:0]  comm_sector,      // Commutation sector 0..5
  output logic                         comm_valid,       // Sector initialised
  output logic                         comm_fault,       // Check mismatch, sticky
  output logic                         comm_check,       // Check performed pulse
  output logic signed [ept_pkg::TURN_W-1:0] turn_count,  // Retained turns
  output logic                         turn_enabled,     // Retention active
  output logic                         inverter_enable   // Inverter drive power
);
  import ept_pkg::*;

  initial begin
    if (COUNTS_REV < 4 || COUNTS_REV > 2**20) $error("COUNTS_REV out of range");
    if (COMM_CYC < 1) $error("COMM_CYC must be positive");
    if (PW != POS_W) $error("PW must equal POS_W");
    if (EDGE_SEP_CYC < 2) $error("Clock too slow to separate edges");
  end

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [10:0] raw_in;
  logic [10:0] syn;
  assign raw_in = {motor_chan_a, motor_chan_b, motor_index, hall_in_1, hall_in_2, hall_in_3,
                   aux_chan_a, aux_chan_b, aux_index, torque_disable_input};

  // Two-stage sync at 4 ns samples each 42 ns edge gap many times
  ept_sync #(.W(11)) u_sync (
    .clock (clock),
    .d     (raw_in),
    .q     (syn)
  );

  ept_quad_t  m_quad;
  ept_quad_t  a_quad;
  logic [2:0] hall;
  logic [1:0] torque_ok;
  assign m_quad = '{chan_a: syn[10], chan_b: syn[9], index: syn[8]};
  assign hall   = {syn[7], syn[6], syn[5]};
  assign a_quad = '{chan_a: syn[4], chan_b: syn[3], index: syn[2]};
  assign torque_ok = syn[1:0];

  // ==========================================================================
  // Decoders
  // ==========================================================================
  ept_count_t m_cnt;
  ept_count_t a_cnt;

  ept_quad_decoder #(.PW(PW)) u_motor (
    .clock  (clock),
    .srst   (srst),
    .quad   (m_quad),
    .sincos (sincos_mode),
    .count  (m_cnt)
  );

  ept_quad_decoder #(.PW(PW)) u_aux (
    .clock  (clock),
    .srst   (srst),
    .quad   (a_quad),
    .sincos (1'b0),
    .count  (a_cnt)
  );

  // ==========================================================================
  // Revolution tracking and synthetic marker
  // ==========================================================================
  localparam int RW = $clog2(COUNTS_REV + 1);
  localparam logic [RW-1:0] REV_LAST = RW'(COUNTS_REV - 1);
  logic [RW-1:0]       rev_pos;
  logic [RW-1:0]       next_rev_pos;
  logic signed [PW-1:0] last_pos;
  logic signed [PW-1:0] next_last_pos;
  logic                wrap_up;
  logic                wrap_dn;
  logic                next_motor_marker;

  always_comb begin
    logic up;
    logic dn;
    up = (m_cnt.position - last_pos) == PW'(1);
    dn = (last_pos - m_cnt.position) == PW'(1);
    next_last_pos = m_cnt.position;
    next_rev_pos  = rev_pos;
    wrap_up = 1'b0;
    wrap_dn = 1'b0;
    if (up) begin
      wrap_up      = (rev_pos == REV_LAST);
      next_rev_pos = wrap_up ? '0 : rev_pos + 1'b1;
    end else if (dn) begin
      wrap_dn      = (rev_pos == '0);
      next_rev_pos = wrap_dn ? REV_LAST : rev_pos - 1'b1;
    end
    // Absolute devices have no index; mark each revolution wrap
    next_motor_marker = absolute_mode ? (wrap_up | wrap_dn) : m_cnt.index_evt;
    if (srst) begin
      next_last_pos     = '0;
      next_rev_pos      = '0;
      next_motor_marker = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    last_pos     <= next_last_pos;
    rev_pos      <= next_rev_pos;
    motor_marker <= next_motor_marker;
  end

  // ==========================================================================
  // Multi-turn retention
  // ==========================================================================
  logic signed [TURN_W-1:0] next_turn_count;
  logic                     next_turn_enabled;
  localparam logic signed [TURN_W-1:0] TURN_ONE = TURN_W'(1);

  function automatic logic [TURN_W-1:0] turn_limit(input ept_turns_t t);
    case (t)
      EPT_TURNS_2K:  turn_limit = TURN_LIM_2K;
      EPT_TURNS_4K:  turn_limit = TURN_LIM_4K;
      EPT_TURNS_64K: turn_limit = TURN_LIM_64K;
      default:       turn_limit = '0;
    endcase
  endfunction : turn_limit

  always_comb begin
    logic signed [TURN_W-1:0] lim;
    lim = signed'(turn_limit(turns_type));
    next_turn_enabled = (turns_type != EPT_TURNS_OFF);
    next_turn_count   = turn_count;
    if (!next_turn_enabled) begin
      next_turn_count = '0;
    end else if (wrap_up) begin
      // Range -lim .. lim-1, wrapping at the ends
      next_turn_count = (turn_count >= lim - TURN_ONE) ? -lim : turn_count + TURN_ONE;
    end else if (wrap_dn) begin
      next_turn_count = (turn_count <= -lim) ? lim - TURN_ONE : turn_count - TURN_ONE;
    end
    if (srst) begin
      next_turn_count   = '0;
      next_turn_enabled = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    turn_count   <= next_turn_count;
    turn_enabled <= next_turn_enabled;
  end

  // ==========================================================================
  // Commutation from Hall sensors
  // ==========================================================================
  ept_comm_state_t     state;
  ept_comm_state_t     next_state;
  logic [2:0]          hall_prev;
  logic [2:0]          next_hall_prev;
  logic [ANGLE_W-1:0]  next_comm_sector;
  logic                next_comm_valid;
  logic                next_comm_fault;
  logic                next_comm_check;
  logic [31:0]         per_cnt;
  logic [31:0]         next_per_cnt;

  // Hall code to sector; 0 and 7 are invalid
  function automatic logic [ANGLE_W-1:0] hall_sector(input logic [2:0] h);
    case (h)
      3'h1:    hall_sector = 3'h0;
      3'h3:    hall_sector = 3'h1;
      3'h2:    hall_sector = 3'h2;
      3'h6:    hall_sector = 3'h3;
      3'h4:    hall_sector = 3'h4;
      3'h5:    hall_sector = 3'h5;
      default: hall_sector = 3'h0;
    endcase
  endfunction : hall_sector

  function automatic logic hall_ok(input logic [2:0] h);
    hall_ok = (h != HALL_NONE_LO) && (h != HALL_NONE_HI);
  endfunction : hall_ok

  // Neighbouring sectors, wrapping after the last one
  function automatic logic sector_near(input logic [ANGLE_W-1:0] a,
                                       input logic [ANGLE_W-1:0] b);
    logic [ANGLE_W-1:0] a_up;
    logic [ANGLE_W-1:0] b_up;
    a_up = (a == ANGLE_W'(HALL_SECTORS - 1)) ? '0 : a + 1'b1;
    b_up = (b == ANGLE_W'(HALL_SECTORS - 1)) ? '0 : b + 1'b1;
    sector_near = (a_up == b) || (b_up == a);
  endfunction : sector_near

  always_comb begin
    logic mismatch;
    logic sect_step;
    next_state       = state;
    next_hall_prev   = hall;
    next_comm_sector = comm_sector;
    next_comm_valid  = comm_valid;
    next_comm_fault  = comm_fault;
    next_comm_check  = 1'b0;
    next_per_cnt     = per_cnt;
    mismatch  = hall_ok(hall) && (hall_sector(hall) != comm_sector);
    sect_step = hall_ok(hall) && (hall != hall_prev);
    case (state)
      CM_INIT: begin
        // Levels are logic only, so open-collector or none both fit
        if (!hall_present) begin
          next_state = CM_NOHAL;
        end else if (hall_ok(hall)) begin
          next_comm_sector = hall_sector(hall);
          next_comm_valid  = 1'b1;
          next_state       = CM_FIRST;
        end
      end
      CM_FIRST: begin
        if (sect_step) begin
          // First Hall edge: check against the tracked sector
          next_comm_check  = 1'b1;
          next_comm_fault  = comm_fault | ~sector_near(hall_sector(hall), comm_sector);
          next_comm_sector = hall_sector(hall);
          next_per_cnt     = '0;
          next_state       = CM_RUN;
        end
      end
      CM_RUN: begin
        // A skipped sector leaves the angle stale for the periodic check
        if (sect_step && sector_near(hall_sector(hall), comm_sector)) begin
          next_comm_sector = hall_sector(hall);
        end
        if (per_cnt >= 32'(COMM_CYC - 1)) begin
          next_per_cnt    = '0;
          next_comm_check = 1'b1;
          next_comm_fault = comm_fault | (mismatch & ~sect_step);
        end else begin
          next_per_cnt = per_cnt + 32'h1;
        end
      end
      CM_NOHAL: begin
        next_comm_valid = 1'b0;
      end
      default: begin
        next_state = CM_INIT;
      end
    endcase
    if (srst) begin
      next_state       = CM_INIT;
      next_hall_prev   = 3'h0;
      next_comm_sector = '0;
      next_comm_valid  = 1'b0;
      next_comm_fault  = 1'b0;
      next_comm_check  = 1'b0;
      next_per_cnt     = '0;
    end
  end

  always_ff @(posedge clock) begin
    state       <= next_state;
    hall_prev   <= next_hall_prev;
    comm_sector <= next_comm_sector;
    comm_valid  <= next_comm_valid;
    comm_fault  <= next_comm_fault;
    comm_check  <= next_comm_check;
    per_cnt     <= next_per_cnt;
  end

  // ==========================================================================
  // Outputs and torque disable
  // ==========================================================================
  logic next_inverter_enable;

  always_comb begin
    // Any channel low removes power at once
    next_inverter_enable = srst ? 1'b0 : (&torque_ok);
  end

  always_ff @(posedge clock) begin
    inverter_enable  <= next_inverter_enable;
    motor_position   <= m_cnt.position;
    motor_quad_error <= m_cnt.error_evt;
    aux_position     <= a_cnt.position;
    aux_marker       <= a_cnt.index_evt;
    aux_quad_error   <= a_cnt.error_evt;
  end

endmodule : ept_encoder_position_tracker

// ---- rtl/ept_pkg.sv ----
package ept_pkg;

  // ==========================================================================
  // Quadrature decoding
  // ==========================================================================
  localparam int POS_W          = 32;
  localparam int COUNTS_PER_CYC = 4;
  localparam real CLK_PERIOD_NS = 4.0;
  localparam real EDGE_SEP_NS   = 42.0;
  // Longest time: round down, at least one cycle
  localparam int EDGE_SEP_CYC   = (int'(EDGE_SEP_NS / CLK_PERIOD_NS - 0.5) < 1) ? 1 :
                                  int'(EDGE_SEP_NS / CLK_PERIOD_NS - 0.5);

  // ==========================================================================
  // Commutation check
  // ==========================================================================
  localparam int  HALL_SECTORS       = 6;
  localparam int  ANGLE_W            = 3;
  localparam real COMM_PERIOD_US     = 1000.0;
  localparam int  COMM_PERIOD_CYC    = int'(COMM_PERIOD_US * 1000.0 / CLK_PERIOD_NS - 0.5);
  localparam logic [2:0] HALL_NONE_LO = 3'h0;
  localparam logic [2:0] HALL_NONE_HI = 3'h7;

  // ==========================================================================
  // Multi-turn retention
  // ==========================================================================
  localparam int TURN_W = 17;
  localparam logic [TURN_W-1:0] TURN_LIM_2K  = 17'h00400;
  localparam logic [TURN_W-1:0] TURN_LIM_4K  = 17'h00800;
  localparam logic [TURN_W-1:0] TURN_LIM_64K = 17'h08000;

  typedef enum logic [1:0] {
    EPT_TURNS_2K  = 2'h0,
    EPT_TURNS_4K  = 2'h1,
    EPT_TURNS_64K = 2'h2,
    EPT_TURNS_OFF = 2'h3
  } ept_turns_t;

  typedef struct packed {
    logic chan_a;
    logic chan_b;
    logic index;
  } ept_quad_t;

  typedef struct packed {
    logic signed [POS_W-1:0] position;
    logic                    index_evt;
    logic                    error_evt;
  } ept_count_t;

  typedef enum logic [3:0] {
    CM_INIT  = 4'h1,
    CM_FIRST = 4'h2,
    CM_RUN   = 4'h4,
    CM_NOHAL = 4'h8
  } ept_comm_state_t;

endpackage : ept_pkg

// ---- rtl/ept_sync.sv ----
`timescale 1ns/10ps
module ept_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,  // System clock
  input  wire logic [W-1:0] d,      // Async input
  output logic      [W-1:0] q       // Synchronised
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // No reset: true pin levels through reset, so no false edge on release
  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge clock) begin
    meta <= next_meta;
    q    <= next_q;
  end
endmodule : ept_sync

// ---- rtl/ept_quad_decoder.sv ----
`timescale 1ns/10ps
module ept_quad_decoder
  import ept_pkg::*;
#(
  parameter int PW = ept_pkg::POS_W
) (
  input  wire logic              clock,    // System clock
  input  wire logic              srst,     // Sync reset
  input  wire ept_pkg::ept_quad_t quad,    // Synchronised A/B/index
  input  wire logic              sincos,   // Sine/cosine direction sense
  output ept_pkg::ept_count_t    count     // Position and events
);
  import ept_pkg::*;

  initial begin
    if (PW < 8 || PW > POS_W) $error("ept_quad_decoder: PW out of range");
  end

  logic      [1:0] prev_ab;
  logic            prev_idx;
  ept_count_t      next_count;
  logic      [1:0] next_prev_ab;
  logic            next_prev_idx;

  // Gray step direction: +1 when A leads B
  function automatic logic [1:0] step(input logic [1:0] p, input logic [1:0] c);
    logic fwd;
    fwd = (p == 2'h0 && c == 2'h2) || (p == 2'h2 && c == 2'h3) ||
          (p == 2'h3 && c == 2'h1) || (p == 2'h1 && c == 2'h0);
    step = (p == c) ? 2'h0 : (p ^ c) == 2'h3 ? 2'h3 : fwd ? 2'h1 : 2'h2;
  endfunction : step

  always_comb begin
    logic [1:0] cur;
    logic [1:0] s;
    cur           = {quad.chan_a, quad.chan_b};
    s             = step(prev_ab, cur);
    next_count    = count;
    next_count.index_evt = quad.index & ~prev_idx;
    next_count.error_evt = (s == 2'h3);
    // Each single-channel edge counts once: four per cycle; both lines at once count nothing
    if ((s == 2'h1 && !sincos) || (s == 2'h2 && sincos)) begin
      next_count.position = count.position + 1'b1;
    end else if ((s == 2'h2 && !sincos) || (s == 2'h1 && sincos)) begin
      next_count.position = count.position - 1'b1;
    end
    next_prev_ab  = cur;
    next_prev_idx = quad.index;
    if (srst) begin
      next_count    = '0;
      // Track present levels so release shows no edge
      next_prev_ab  = cur;
      next_prev_idx = quad.index;
    end
  end

  always_ff @(posedge clock) begin
    count    <= next_count;
    prev_ab  <= next_prev_ab;
    prev_idx <= next_prev_idx;
  end
endmodule : ept_quad_decoder

// ---- bench/ept_encoder_model.sv ----
`timescale 1ns/10ps
module ept_encoder_model (
  input  wire logic       clock,   // System clock
  input  wire logic [1:0] move,    // 1 forward, 2 back, 3 both lines at once
  output logic            chan_a,  // A line
  output logic            chan_b,  // B line
  output logic            index    // Index, once per 64 phases
);
  logic [5:0] pos;

  initial pos = 6'h00;

  // ==========================================================================
  // Phase walks Gray order 00, 10, 11, 01 on (A,B)
  // ==========================================================================
  always @(posedge clock) begin
    case (move)
      2'h1: pos <= pos + 6'h01;
      2'h2: pos <= pos - 6'h01;
      2'h3: pos <= pos + 6'h02;
      default: pos <= pos;
    endcase
  end

  assign chan_a = pos[1] ^ pos[0];
  assign chan_b = pos[1];
  assign index  = (pos == 6'h00);
endmodule : ept_encoder_model

// ---- bench/ept_tracker_sva.sv ----
`timescale 1ns/10ps
module ept_tracker_sva
  import ept_pkg::*;
#(
  parameter int PW = 32
) (
  input wire logic                          clock,                // System clock
  input wire logic                          srst,                 // Sync reset
  input wire logic                          motor_chan_a,         // Motor A
  input wire logic                          motor_chan_b,         // Motor B
  input wire logic                          aux_chan_a,           // Aux A
  input wire logic                          aux_chan_b,           // Aux B
  input wire logic [1:0]                    torque_disable_input, // Torque enables
  input wire logic                          sincos_mode,          // Sine/cosine sense
  input wire ept_pkg::ept_turns_t           turns_type,           // Turn range
  input wire logic signed [PW-1:0]          motor_position,       // Motor count
  input wire logic                          motor_quad_error,     // Motor error
  input wire logic signed [PW-1:0]          aux_position,         // Aux count
  input wire logic [ept_pkg::ANGLE_W-1:0]   comm_sector,          // Sector
  input wire logic                          comm_valid,           // Sector valid
  input wire logic                          comm_fault,           // Sticky fault
  input wire logic                          comm_check,           // Check pulse
  input wire logic signed [ept_pkg::TURN_W-1:0] turn_count,       // Turns
  input wire logic                          turn_enabled,         // Retention on
  input wire logic                          inverter_enable       // Drive power
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // ==========================================================================
  // Edge sequences
  // ==========================================================================
  sequence s_motor_a_lead;
    $rose(motor_chan_a) && !motor_chan_b && $stable(motor_chan_b);
  endsequence

  sequence s_aux_a_lead;
    $rose(aux_chan_a) && !aux_chan_b && $stable(aux_chan_b);
  endsequence

  a_square_up: assert property (s_motor_a_lead ##0 !sincos_mode |-> ##4
    motor_position - $past(motor_position) == 1) else $error("square sense wrong");
  a_sincos_down: assert property (s_motor_a_lead ##0 sincos_mode |-> ##4
    motor_position - $past(motor_position) == -1) else $error("sincos sense wrong");
  a_aux_up: assert property (s_aux_a_lead |-> ##4
    aux_position - $past(aux_position) == 1) else $error("aux sense wrong");
  a_unit_step: assert property ($changed(motor_position) |->
    (motor_position - $past(motor_position)) inside {1, -1}) else $error("step not unit");
  a_err_flag: assert property ($changed(motor_chan_a) && $changed(motor_chan_b)
    |-> ##4 motor_quad_error) else $error("no error pulse");
  a_err_nocount: assert property (motor_quad_error |-> $stable(motor_position))
    else $error("count moved on error");
  a_sto_drop: assert property ($fell(torque_disable_input[1]) |->
    ##4 !inverter_enable) else $error("inverter not removed");
  a_sector_range: assert property (comm_valid |-> comm_sector < 3'h6)
    else $error("sector out of range");
  a_fault_hold: assert property (comm_fault |=> comm_fault)
    else $error("fault not sticky");
  a_check_pulse: assert property (comm_check |=> !comm_check)
    else $error("check pulse too long");
  a_turn_range: assert property (turn_enabled && turns_type == EPT_TURNS_2K |->
    turn_count >= -17'sd1024 && turn_count <= 17'sd1023) else $error("turns out of range");
  a_turn_off: assert property (turn_enabled |-> turns_type != EPT_TURNS_OFF)
    else $error("retention on when off");
endmodule : ept_tracker_sva

bind ept_encoder_position_tracker ept_tracker_sva #(.PW(PW)) ept_tracker_sva_i (
  .clock(clock), .srst(srst), .motor_chan_a(motor_chan_a), .motor_chan_b(motor_chan_b),
  .aux_chan_a(aux_chan_a), .aux_chan_b(aux_chan_b),
  .torque_disable_input(torque_disable_input), .sincos_mode(sincos_mode),
  .turns_type(turns_type), .motor_position(motor_position),
  .motor_quad_error(motor_quad_error), .aux_position(aux_position),
  .comm_sector(comm_sector), .comm_valid(comm_valid), .comm_fault(comm_fault),
  .comm_check(comm_check), .turn_count(turn_count), .turn_enabled(turn_enabled),
  .inverter_enable(inverter_enable)
);

// ---- bench/ept_testbench.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %0h want %0h", $time, g, e); end end
module testbench;
  import ept_pkg::*;
  logic               clock = 1'b0;
  logic               srst = 1'b1;
  logic [1:0]         m_mv = 2'h0, x_mv = 2'h0, tdi = 2'h3;
  logic               ma, mb, mi, xa, xb, xi;
  logic [2:0]         hall = 3'h0, csec;
  logic               sincos = 1'b0, absm = 1'b0, hallp = 1'b0;
  ept_turns_t         turns = EPT_TURNS_OFF;
  logic signed [31:0] mpos, xpos, exp_m, exp_x;
  logic               mmark, merr, xmark, xerr, cvalid, cfault, ccheck, tena, inv;
  logic signed [16:0] tcnt;
  int                 failures = 0, n_checks = 0, marks = 0, errs = 0, i;
  int                 xmarks = 0, xerrs = 0;

  always #2 clock = ~clock;
  always @(posedge clock) begin
    if (mmark === 1'b1) marks++;
    if (merr === 1'b1) errs++;
    if (xmark === 1'b1) xmarks++;
    if (xerr === 1'b1) xerrs++;
  end

  ept_encoder_position_tracker #(.PW(32), .COUNTS_REV(16), .COMM_CYC(50))
    ept_encoder_position_tracker_i (
    .clock(clock), .srst(srst), .motor_chan_a(ma), .motor_chan_b(mb), .motor_index(mi),
    .hall_in_1(hall[0]), .hall_in_2(hall[1]), .hall_in_3(hall[2]), .aux_chan_a(xa),
    .aux_chan_b(xb), .aux_index(xi), .torque_disable_input(tdi), .sincos_mode(sincos),
    .absolute_mode(absm), .turns_type(turns), .hall_present(hallp),
    .motor_position(mpos), .motor_marker(mmark), .motor_quad_error(merr),
    .aux_position(xpos), .aux_marker(xmark), .aux_quad_error(xerr), .comm_sector(csec),
    .comm_valid(cvalid), .comm_fault(cfault), .comm_check(ccheck), .turn_count(tcnt),
    .turn_enabled(tena), .inverter_enable(inv));
  ept_encoder_model ept_encoder_model_i (.clock(clock), .move(m_mv), .chan_a(ma),
    .chan_b(mb), .index(mi));
  ept_encoder_model ept_encoder_model_aux (.clock(clock), .move(x_mv), .chan_a(xa),
    .chan_b(xb), .index(xi));

  task automatic results;
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // ==========================================================================
  // Stimulus helpers, 11 cycles (44 ns) between line edges
  // ==========================================================================
  task automatic mv(input logic [1:0] m, input logic aux, input int n);
    repeat (n) begin
      @(posedge clock); #1;
      if (aux) x_mv = m; else m_mv = m;
      @(posedge clock); #1;
      x_mv = 2'h0; m_mv = 2'h0;
      repeat (9) @(posedge clock);
      #1;
    end
  endtask : mv

  task automatic do_reset;
    @(posedge clock); #1 srst = 1'b1;
    repeat (6) @(posedge clock);
    #1;
    `CHK(mpos, 32'sh0) `CHK(inv, 1'b0)
    srst = 1'b0;
    exp_m = 0;
    exp_x = 0;
  endtask : do_reset

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_square;
    mv(2'h1, 1'b0, 8); exp_m += 8;
    `CHK(mpos, exp_m)
    mv(2'h2, 1'b0, 3); exp_m -= 3;
    `CHK(mpos, exp_m)
  endtask : t_square

  task automatic t_error;
    errs = 0;
    mv(2'h3, 1'b0, 1);
    `CHK(errs, 1)
    `CHK(mpos, exp_m)
  endtask : t_error

  task automatic t_sincos;
    sincos = 1'b1;
    mv(2'h1, 1'b0, 4); exp_m -= 4;
    `CHK(mpos, exp_m)
    xmarks = 0;
    xerrs = 0;
    mv(2'h1, 1'b1, 5); exp_x += 5;
    `CHK(xpos, exp_x)
    `CHK(mpos, exp_m)
    // Back to phase zero: the aux index rises once
    mv(2'h2, 1'b1, 5); exp_x -= 5;
    `CHK(xpos, exp_x)
    `CHK(xmarks, 1)
    mv(2'h3, 1'b1, 1);
    `CHK(xerrs, 1)
    `CHK(xpos, exp_x)
    sincos = 1'b0;
  endtask : t_sincos

  task automatic t_sto;
    `CHK(inv, 1'b1)
    tdi = 2'h2; repeat (8) @(posedge clock); #1;
    `CHK(inv, 1'b0)
    tdi = 2'h1; repeat (8) @(posedge clock); #1;
    `CHK(inv, 1'b0)
    tdi = 2'h3; repeat (8) @(posedge clock); #1;
    `CHK(inv, 1'b1)
    `CHK(cvalid, 1'b0)
    `CHK(tena, 1'b0)
  endtask : t_sto

  task automatic t_hall;
    i = 0;
    while (cvalid !== 1'b1 && i < 40) begin @(posedge clock); #1; i++; end
    `CHK(cvalid, 1'b1)
    `CHK(csec, 3'h4)
    `CHK(tena, 1'b1)
    hall = 3'h3;
    for (int k = 0; k < 2; k++) begin
      @(posedge clock); #1; i = 0;
      while (ccheck !== 1'b1 && i < 80) begin @(posedge clock); #1; i++; end
      `CHK(ccheck, 1'b1)
      `CHK(csec, 3'h3)
    end
    `CHK(cfault, 1'b0)
    // Sector 3 to sector 0 skips sectors: the next periodic check faults
    hall = 3'h4;
    repeat (4) @(posedge clock);
    #1;
    i = 0;
    while (ccheck !== 1'b1 && i < 80) begin @(posedge clock); #1; i++; end
    `CHK(ccheck, 1'b1)
    `CHK(cfault, 1'b1)
    `CHK(csec, 3'h3)
  endtask : t_hall

  task automatic t_marker;
    marks = 0;
    mv(2'h1, 1'b0, 16);
    `CHK(marks, 1)
    `CHK(tcnt, 17'sd1)
    mv(2'h2, 1'b0, 32);
    `CHK(marks, 3)
    `CHK(tcnt, -17'sd1)
  endtask : t_marker

  initial begin
    #40000;
    failures++;
    results();
  end

  initial begin
    do_reset();
    t_square();
    t_error();
    t_sincos();
    t_sto();
    hallp = 1'b1; hall = 3'h1; absm = 1'b1; turns = EPT_TURNS_2K;
    do_reset();
    t_hall();
    t_marker();
    results();
  end
endmodule : testbench
